//--- hdl/mcg_div.sv
// Prescaler stage: divides a stream of tick pulses by a ratio.
`default_nettype none
module mcg_div
    import mcg_pkg::*;
(
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // Tick stream and result.
    mcg_div_if.div    p
);
    mcg_ratio_t cnt_q;
    logic       tick_q;
    logic       lvl_q;

    // Wrap point and high half of the divided waveform.
    wire        wrap_w = cnt_q >= 6'(p.ratio - 6'h01);
    mcg_ratio_t cnt_d;
    assign cnt_d = wrap_w ? 6'h00 : 6'(cnt_q + 6'h01);
    wire [5:0]  half_w = 6'((p.ratio + 6'h01) >> 1);

    // Counting only moves on input ticks, so the output phase is tied to them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= 6'h00;
            tick_q <= 1'b0;
            lvl_q  <= 1'b1;
        end else begin
            tick_q <= p.tick_in & wrap_w;
            if (p.tick_in) begin
                cnt_q <= cnt_d;
                lvl_q <= cnt_d < half_w;
            end
        end
    end

    assign p.tick_out = tick_q;
    assign p.level    = lvl_q;
endmodule : mcg_div
`default_nettype wire

//--- hdl/mcg_div_if.sv
// Carrier between the generator core and one prescaler stage.
`default_nettype none
interface mcg_div_if;
    import mcg_pkg::*;
    logic       tick_in;
    mcg_ratio_t ratio;
    logic       tick_out;
    logic       level;
    modport ctl (output tick_in, ratio, input tick_out, level);
    modport div (input tick_in, ratio, output tick_out, level);
endinterface : mcg_div_if
`default_nettype wire

//--- hdl/mcg_pkg.sv
// Types shared by the master clock generator modules.
`default_nettype none
package mcg_pkg;
    typedef enum logic [1:0] {LOOP_OFF, LOOP_ACQ, LOOP_LOCK} mcg_loop_t;
    typedef logic [5:0] mcg_ratio_t;
endpackage : mcg_pkg
`default_nettype wire

//--- hdl/mcg_regs.svh
// Register offsets, field positions and reset values of the master clock generator.
`ifndef MCG_REGS_SVH
`define MCG_REGS_SVH

// Byte offsets on the APB.
`define MCG_CTRL_OFS  12'h000
`define MCG_SYSC_OFS  12'h004
`define MCG_STAT_OFS  12'h008

// Fields of clock_generation_control.
`define MCG_SRC_LSB   0
`define MCG_SRC_MSB   1
`define MCG_VB_LSB    2
`define MCG_VB_MSB    3
`define MCG_IDIV_LSB  4
`define MCG_IDIV_MSB  5
`define MCG_ODIV_LSB  6
`define MCG_ODIV_MSB  9
`define MCG_MUL_LSB   10
`define MCG_MUL_MSB   14
`define MCG_CTRL_RST  15'h0000
`define MCG_ODIV_MAX  4'he

// Fields of system_config_one.
`define MCG_HALVE_BIT 0
`define MCG_SYSC_RST  1'b0

// Oscillator model increment limits per band, scaled to the reference clock.
`define MCG_B0_MIN    16'h0800
`define MCG_B0_MAX    16'h0c00
`define MCG_B1_MIN    16'h0c00
`define MCG_B1_MAX    16'h1000
`define MCG_B2_MIN    16'h1000
`define MCG_B2_MAX    16'h1400

`endif

//--- hdl/mcg_top.sv
// Master clock generator: bypass prescaler, loop model, CPU and system clock derivation.
`include "mcg_regs.svh"
`default_nettype none
module mcg_top
    import mcg_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Oscillator input, synchronous to ref_clk.
    input  wire logic        osc_in,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Generated clock levels and their rising-edge enables.
    output logic             mclk_out,
    output logic             mclk_en,
    output logic             cpu_clk,
    output logic             cpu_en,
    output logic             sys_clk,
    output logic             sys_en
);
    // Registers.
    logic [14:0] ctrl_q;
    logic        halve_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        osc_q;
    logic        osc_p_q;
    logic        mclk_q;
    logic        mclk_en_q;
    logic        cpu_q;
    logic        cpu_en_q;
    logic        sys_q;
    logic        sys_en_q;
    logic [15:0] acc_q;
    logic [15:0] inc_q;
    logic        vco_tick_q;
    logic [7:0]  vcnt_q;
    mcg_loop_t   state_q;

    mcg_div_if dif [2] ();

    // Two identical prescaler stages: input side and output side.
    for (genvar i = 0; i < 2; i++) begin : g_div
        mcg_div u_div (
            .ref_clk (ref_clk),
            .rst     (rst),
            .p       (dif[i])
        );
    end

    // APB decode; the answer is prepared in the setup cycle so it comes from flops.
    wire        setup_w  = psel & ~penable;
    wire        acc_w    = psel & penable & pready_q;
    wire        wr_w     = acc_w & pwrite;
    wire        hit_ctrl = paddr == `MCG_CTRL_OFS;
    wire        hit_sysc = paddr == `MCG_SYSC_OFS;
    wire        hit_stat = paddr == `MCG_STAT_OFS;
    wire        hit_any  = hit_ctrl | hit_sysc | hit_stat;

    // Field views of the control register.
    wire [1:0]  src_w  = ctrl_q[`MCG_SRC_MSB:`MCG_SRC_LSB];
    wire [1:0]  vb_w   = ctrl_q[`MCG_VB_MSB:`MCG_VB_LSB];
    wire [1:0]  idiv_w = ctrl_q[`MCG_IDIV_MSB:`MCG_IDIV_LSB];
    wire [3:0]  odiv_w = ctrl_q[`MCG_ODIV_MSB:`MCG_ODIV_LSB];
    wire [4:0]  mul_w  = ctrl_q[`MCG_MUL_MSB:`MCG_MUL_LSB];
    wire        pll_on = src_w == 2'b11;

    // Output setting saturates at its top value so a stray 15 cannot exceed the range.
    wire [3:0]  wodiv  = pwdata[`MCG_ODIV_MSB:`MCG_ODIV_LSB];
    wire [3:0]  odiv_s = (wodiv > `MCG_ODIV_MAX) ? `MCG_ODIV_MAX : wodiv;
    wire [14:0] ctrl_wd = {pwdata[`MCG_MUL_MSB:`MCG_MUL_LSB], odiv_s,
                           pwdata[`MCG_IDIV_MSB:`MCG_SRC_LSB]};

    // Read data multiplexer; unmapped offsets read zero and signal an error.
    wire        locked_w = state_q == LOOP_LOCK;
    wire        vb_res_w = vb_w == 2'b11;
    wire [31:0] stat_w   = {inc_q, 13'h0000, vb_res_w, locked_w, pll_on};
    wire [31:0] rd_w     = hit_ctrl ? {17'h00000, ctrl_q} :
                           hit_sysc ? {31'h00000000, halve_q} :
                           hit_stat ? stat_w : 32'h00000000;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup_w;
            pslverr_q <= setup_w & ~hit_any;
            prdata_q  <= setup_w ? rd_w : 32'h00000000;
        end
    end

    // Software settings; status is read-only and writes to it are dropped.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= `MCG_CTRL_RST;
            halve_q <= `MCG_SYSC_RST;
        end else begin
            if (wr_w && hit_ctrl) begin
                ctrl_q <= ctrl_wd;
            end
            if (wr_w && hit_sysc) begin
                halve_q <= pwdata[`MCG_HALVE_BIT];
            end
        end
    end

    // Oscillator sampling and rising-edge detect.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_q   <= 1'b0;
            osc_p_q <= 1'b0;
        end else begin
            osc_q   <= osc_in;
            osc_p_q <= osc_q;
        end
    end

    // Mode and prescaler ratios.
    wire [5:0]  idiv_n     = {4'h0, idiv_w} + 6'h01;
    wire [5:0]  odiv_n     = {2'b00, odiv_w} + 6'h01;
    wire [5:0]  byp_n      = 6'(idiv_n * odiv_n);
    wire        byp_direct = byp_n == 6'h01;
    wire        osc_rise   = osc_q & ~osc_p_q;

    // Stage 0 divides the oscillator: whole ratio in bypass, input ratio as loop reference.
    assign dif[0].tick_in = osc_rise;
    assign dif[0].ratio   = pll_on ? idiv_n : byp_n;
    // Stage 1 is the output prescaler on the oscillator model ticks.
    assign dif[1].tick_in = vco_tick_q;
    assign dif[1].ratio   = odiv_n;
    wire        ref_tick  = dif[0].tick_out;

    // Band limits; the reserved code falls back to the lowest band.
    wire [15:0] bmin = (vb_w == 2'b01) ? `MCG_B1_MIN :
                       (vb_w == 2'b10) ? `MCG_B2_MIN : `MCG_B0_MIN;
    wire [15:0] bmax = (vb_w == 2'b01) ? `MCG_B1_MAX :
                       (vb_w == 2'b10) ? `MCG_B2_MAX : `MCG_B0_MAX;

    // Model ticks run at twice the oscillator model rate; the master clock toggles on output ticks.
    wire [7:0]  tgt_w  = 8'({2'b00, mul_w, 1'b0} + 8'h02);
    wire        slow_w = vcnt_q < tgt_w;
    wire        fast_w = vcnt_q > tgt_w;
    // One step per reference window keeps every frequency change gradual.
    wire        up_w   = (inc_q < bmin) | (slow_w & (inc_q < bmax));
    wire        dn_w   = (inc_q > bmax) | (fast_w & (inc_q > bmin));
    wire [15:0] inc_adj = up_w ? 16'(inc_q + 16'h0001) :
                          dn_w ? 16'(inc_q - 16'h0001) : inc_q;
    wire [16:0] acc_sum = {1'b0, acc_q} + {1'b0, inc_q};
    wire [7:0]  vcnt_inc = (vcnt_q == 8'hff) ? vcnt_q : 8'(vcnt_q + 8'h01);

    // Loop state machine.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= LOOP_OFF;
            inc_q   <= `MCG_B0_MIN;
        end else begin
            case (state_q)
                LOOP_OFF: begin
                    if (pll_on) begin
                        state_q <= LOOP_ACQ;
                        inc_q   <= bmin;
                    end
                end
                LOOP_ACQ, LOOP_LOCK: begin
                    if (!pll_on) begin
                        state_q <= LOOP_OFF;
                    end else if (ref_tick) begin
                        inc_q   <= inc_adj;
                        state_q <= (!slow_w && !fast_w) ? LOOP_LOCK : LOOP_ACQ;
                    end
                end
                default: begin
                    state_q <= LOOP_OFF;
                end
            endcase
        end
    end

    // Oscillator model accumulator and per-window tick counter; idle outside loop mode.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_q      <= 16'h0000;
            vco_tick_q <= 1'b0;
            vcnt_q     <= 8'h00;
        end else begin
            acc_q      <= (state_q == LOOP_OFF) ? 16'h0000 : acc_sum[15:0];
            vco_tick_q <= (state_q != LOOP_OFF) & pll_on & acc_sum[16];
            if (ref_tick) begin
                vcnt_q <= 8'h00;
            end else if (vco_tick_q) begin
                vcnt_q <= vcnt_inc;
            end
        end
    end

    // Master clock level selection.
    wire        mclk_d = pll_on ? (dif[1].tick_out ? ~mclk_q : mclk_q) :
                         byp_direct ? osc_q : dif[0].level;
    wire        mclk_rise = mclk_d & ~mclk_q;
    // Halving toggles on master rising edges, so the CPU edges stay aligned to master edges.
    wire        cpu_d  = halve_q ? (mclk_rise ? ~cpu_q : cpu_q) : mclk_d;
    wire        cpu_rise = cpu_d & ~cpu_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mclk_q    <= 1'b0;
            mclk_en_q <= 1'b0;
            cpu_q     <= 1'b0;
            cpu_en_q  <= 1'b0;
            sys_q     <= 1'b0;
            sys_en_q  <= 1'b0;
        end else begin
            mclk_q    <= mclk_d;
            mclk_en_q <= mclk_rise;
            cpu_q     <= cpu_d;
            cpu_en_q  <= cpu_rise;
            sys_q     <= cpu_d;
            sys_en_q  <= cpu_rise;
        end
    end

    // Ports come straight from the flops above.
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign mclk_out = mclk_q;
    assign mclk_en  = mclk_en_q;
    assign cpu_clk  = cpu_q;
    assign cpu_en   = cpu_en_q;
    assign sys_clk  = sys_q;
    assign sys_en   = sys_en_q;

    // Checks on the generated clocks and the loop.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_bypass_no_vco: assert property (!pll_on |=> !vco_tick_q)
        else $error("model ticks while in bypass");
    a_bypass_divided: assert property (!pll_on && !byp_direct |=> mclk_q == $past(dif[0].level))
        else $error("bypass master clock not from the prescaler");
    a_direct_follow: assert property (!pll_on && byp_direct |=> mclk_q == $past(osc_q))
        else $error("direct bypass does not copy the oscillator");
    a_odiv_limit: assert property (odiv_w <= `MCG_ODIV_MAX && byp_n <= 6'd60)
        else $error("output setting beyond its top value");
    a_loop_start: assert property (pll_on && state_q == LOOP_OFF
                                   |=> state_q == LOOP_ACQ && inc_q == $past(bmin))
        else $error("loop did not start at the band floor");
    a_inc_gradual: assert property ($past(state_q) != LOOP_OFF && state_q != LOOP_OFF
                                    |-> 16'(inc_q - $past(inc_q)) inside {16'h0000, 16'h0001, 16'hffff})
        else $error("loop frequency jumped");
    a_loop_toggle: assert property (pll_on && dif[1].tick_out |=> mclk_q != $past(mclk_q))
        else $error("master clock missed an output tick");
    a_cpu_full: assert property (!$past(halve_q) && !$past(halve_q, 2) |-> cpu_en_q == mclk_en_q)
        else $error("full rate CPU edge differs from master edge");
    a_cpu_half: assert property ($past(halve_q) && cpu_en_q |-> mclk_en_q)
        else $error("halved CPU edge without master edge");
    a_sys_equal: assert property (sys_en_q == cpu_en_q && sys_q == cpu_q)
        else $error("system clock differs from CPU clock");
    a_band_hold: assert property (state_q != LOOP_OFF && pll_on && !wr_w && inc_q >= bmin && inc_q <= bmax
                                  |=> inc_q >= bmin && inc_q <= bmax)
        else $error("model left the selected band");
    // Leaving loop mode stops the model at once and clears its phase.
    a_loop_off: assert property (!pll_on && state_q != LOOP_OFF |=> state_q == LOOP_OFF)
        else $error("loop kept running after bypass was selected");
    a_acc_idle: assert property (state_q == LOOP_OFF |=> acc_q == 16'h0000)
        else $error("model phase moved while the loop was off");
    // A window that hits the target locks; one that misses drops back to acquiring.
    a_lock_hit: assert property (state_q != LOOP_OFF && pll_on && ref_tick && !slow_w && !fast_w
                                 |=> locked_w)
        else $error("matching window did not lock");
    a_lock_miss: assert property (state_q != LOOP_OFF && pll_on && ref_tick && (slow_w || fast_w)
                                  |=> state_q == LOOP_ACQ)
        else $error("missed window did not return to acquiring");
    // The bus answer is a one-cycle pulse, and an error only ever rides on it.
    a_ready_single: assert property (pready_q |=> !pready_q)
        else $error("ready held for more than one cycle");
    a_err_ready: assert property (pslverr_q |-> pready_q)
        else $error("error flag without ready");
    // Writes are stored with the output setting already clamped.
    a_ctrl_store: assert property (wr_w && hit_ctrl |=> ctrl_q == $past(ctrl_wd))
        else $error("control write not stored as clamped");
    // A halved CPU clock flips on every master rising edge and holds between them.
    a_half_toggle: assert property (halve_q && mclk_rise |=> cpu_q != $past(cpu_q))
        else $error("halved CPU clock missed a master edge");
    a_half_steady: assert property (halve_q && !mclk_rise |=> cpu_q == $past(cpu_q))
        else $error("halved CPU clock moved between master edges");

    c_lock: cover property (state_q == LOOP_ACQ ##1 state_q == LOOP_LOCK);
    c_half_edge: cover property (halve_q && cpu_en_q);
    c_direct_rise: cover property (!pll_on && byp_direct && mclk_en_q);
    c_loop_edge: cover property (pll_on && mclk_en_q);
    // Lock reached in the top band, where the model runs fastest.
    c_band_top: cover property (pll_on && vb_w == 2'b10 && locked_w);
endmodule : mcg_top
`default_nettype wire

//--- sim/tb_master_clock_generation.sv
// Self-checking bench for the master clock generator: registers, bypass division, loop lock and CPU clock.
`include "mcg_regs.svh"
`default_nettype none
`define CHK(g, e) chk((g), (e))
module tb_master_clock_generation;
    import mcg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk = 1'b0, rst = 1'b1, osc_in = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, mclk_out, mclk_en, cpu_clk, cpu_en, sys_clk, sys_en;
    int          miscompares = 0, tests_run = 0, osc_half = 0, osc_cnt = 0;
    logic [15:0] rnd = 16'h001d, osc_rnd = 16'h001d;
    logic        copy_chk = 1'b0, osc_d1 = 1'b0, osc_d2 = 1'b0;

    mcg_top u_dut (.ref_clk(ref_clk), .rst(rst), .osc_in(osc_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mclk_out(mclk_out), .mclk_en(mclk_en), .cpu_clk(cpu_clk),
        .cpu_en(cpu_en), .sys_clk(sys_clk), .sys_en(sys_en));

    // The 200 MHz reference clock.
    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [31:0] ctrl(input int src, input int vb, input int idv, input int odv, input int mul);
        return 32'(src) | 32'(vb) << `MCG_VB_LSB | 32'(idv) << `MCG_IDIV_LSB
            | 32'(odv) << `MCG_ODIV_LSB | 32'(mul) << `MCG_MUL_LSB;
    endfunction : ctrl

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task test_done;
        $display("Comparisons %0d, mismatch count %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task timeout;
        miscompares++;
        test_done();
    endtask : timeout

    // One APB transfer; the request stands until pready is seen high at a rising edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int g;
        g = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            g++;
        end while (pready !== 1'b1 && g < 50);
        if (g >= 50) timeout();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    // Counts oscillator rises and CPU enables across k master clock periods, starting at a master edge.
    task run(input int k, output int nosc, output int ncpu);
        int   n, g;
        logic op;
        n = 0;
        g = 0;
        nosc = 0;
        ncpu = 0;
        do begin
            @(posedge ref_clk);
            g++;
        end while (mclk_en !== 1'b1 && g < 20000);
        op = osc_in;
        while (n < k && g < 60000) begin
            @(posedge ref_clk);
            g++;
            if (osc_in && !op) nosc++;
            op = osc_in;
            if (cpu_en === 1'b1) ncpu++;
            if (mclk_en === 1'b1) n++;
        end
        if (g >= 60000) timeout();
    endtask : run

    // Oscillator: random half periods of 4 to 7 cycles, or a fixed half period once the loop is tested.
    always @(posedge ref_clk) begin
        if (osc_cnt == 0) begin
            osc_in <= ~osc_in;
            osc_rnd = lfsr(osc_rnd);
            osc_cnt <= (osc_half != 0) ? osc_half - 1 : 3 + osc_rnd[1:0];
        end else begin
            osc_cnt <= osc_cnt - 1;
        end
    end

    // In 1:1 bypass the master clock copies the oscillator two cycles later, duty cycle included.
    always @(posedge ref_clk) begin
        if (copy_chk) `CHK(mclk_out, osc_d2);
        osc_d2 <= osc_d1;
        osc_d1 <= osc_in;
    end

    // The peripheral clock must never drift from the CPU clock.
    always @(posedge ref_clk) begin
        if (!rst) `CHK({sys_clk, sys_en}, {cpu_clk, cpu_en});
    end

    // Main sequence.
    initial begin
        logic [31:0] r;
        logic        e;
        int          no, nc, i, o, m, v, lo, cur, prev, done;
        repeat (12) @(posedge ref_clk);
        `CHK({mclk_out, cpu_clk, pready}, 3'h0);
        rst <= 1'b0;
        apb(1'b0, `MCG_CTRL_OFS, 32'h0, r, e);
        `CHK(r, 32'h0);
        apb(1'b0, `MCG_SYSC_OFS, 32'h0, r, e);
        `CHK(r, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, r, e);
        `CHK(e, 1'b1);
        `CHK(r, 32'h0);
        wr(`MCG_STAT_OFS, 32'hffff_ffff);
        apb(1'b0, `MCG_STAT_OFS, 32'h0, r, e);
        `CHK(r[2:0], 3'h0);
        copy_chk <= 1'b1;
        repeat (300) @(posedge ref_clk);
        copy_chk <= 1'b0;
        // Bypass: the extremes first, then random settings over every non-loop source code.
        for (int t = 0; t < 8; t++) begin
            rnd = lfsr(rnd);
            i = (t == 0) ? 3 : rnd[1:0];
            o = (t == 0) ? 15 : (t == 1) ? 14 : rnd[5:2];
            v = (rnd[7:6] == 2'b11) ? 2 : rnd[7:6];
            wr(`MCG_CTRL_OFS, ctrl(t % 3, v, i, o, rnd[12:8]));
            o = (o > 14) ? 14 : o;
            apb(1'b0, `MCG_CTRL_OFS, 32'h0, r, e);
            `CHK(r, ctrl(t % 3, v, i, o, rnd[12:8]));
            wr(`MCG_SYSC_OFS, 32'(t % 2));
            run(1, no, nc);
            run(4, no, nc);
            `CHK(no, 4 * (i + 1) * (o + 1));
            `CHK(nc, (t % 2 == 1) ? 2 : 4);
        end
        // Loop: each usable band at its floor, then the lowest band again with another output setting.
        // The loop is switched off first, since a band change while running would crawl there step by step.
        wr(`MCG_SYSC_OFS, 32'h0);
        osc_half = 16;
        repeat (64) @(posedge ref_clk);
        for (int b = 0; b < 4; b++) begin
            m = (b == 3) ? 1 : b + 1;
            o = b % 2;
            lo = (b == 1) ? 'h0c00 : (b == 2) ? 'h1000 : 'h0800;
            wr(`MCG_CTRL_OFS, 32'h0);
            wr(`MCG_CTRL_OFS, ctrl(3, b % 3, 3, o, m));
            prev = -1;
            done = 0;
            for (int p = 0; p < 4000 && done == 0; p++) begin
                apb(1'b0, `MCG_STAT_OFS, 32'h0, r, e);
                cur = r[31:16];
                if (prev >= 0) `CHK(cur >= prev - 1 && cur <= prev + 1, 1'b1);
                prev = cur;
                done = r[1];
            end
            if (done == 0) timeout();
            `CHK(r[2:0], 3'b011);
            `CHK(cur >= lo && cur <= lo + 'h400, 1'b1);
            run(1, no, nc);
            run(2 * (m + 1), no, nc);
            `CHK(no >= 8 * (o + 1) - 1 && no <= 8 * (o + 1) + 1, 1'b1);
        end
        wr(`MCG_CTRL_OFS, 32'h0);
        apb(1'b0, `MCG_STAT_OFS, 32'h0, r, e);
        `CHK(r[1:0], 2'h0);
        test_done();
    end
endmodule : tb_master_clock_generation
`default_nettype wire
